// >>> gcsc_params.svh
// Constants for the gauge control and status command block
`ifndef GCSC_PARAMS_SVH
`define GCSC_PARAMS_SVH
`define GCSC_OFF_CTRL 8'h00
`define GCSC_OFF_TEMP 8'h02
`define GCSC_OFF_VOLT 8'h04
`define GCSC_OFF_FLAGS 8'h06
`define GCSC_OFF_NAC 8'h08
`define GCSC_OFF_FAC 8'h0A
`define GCSC_OFF_RM 8'h0C
`define GCSC_OFF_FCC 8'h0E
`define GCSC_OFF_AI 8'h10
`define GCSC_OFF_SI 8'h12
`define GCSC_OFF_MLI 8'h14
`define GCSC_OFF_AP 8'h18
`define GCSC_OFF_SOC 8'h1C
`define GCSC_OFF_ITEMP 8'h1E
`define GCSC_SC_STATUS 16'h0000
`define GCSC_SC_IDENT 16'h0001
`define GCSC_SC_FWREV 16'h0002
`define GCSC_SC_HWREV 16'h0003
`define GCSC_SC_PREV 16'h0007
`define GCSC_SC_INSERT 16'h000C
`define GCSC_SC_REMOVE 16'h000D
`define GCSC_SC_HIB_SET 16'h0011
`define GCSC_SC_HIB_CLR 16'h0012
`define GCSC_SC_CFG 16'h0013
`define GCSC_SC_RESTORE 16'h0015
`define GCSC_SC_SEAL 16'h0020
`define GCSC_SC_FULLRST 16'h0041
`define GCSC_SC_SOFTRST 16'h0042
`define GCSC_PREV_LIMIT 16'h0015
// Status word bit positions
`define GCSC_ST_SEALED 13
`define GCSC_ST_CALIBRATION_ACTIVE_BIT 12
`define GCSC_ST_CCA 11
`define GCSC_ST_BCA 10
`define GCSC_ST_QLEARN 9
`define GCSC_ST_RLEARN 8
`define GCSC_ST_HIB 6
`define GCSC_ST_SLEEP 4
`define GCSC_ST_CPWR 3
`define GCSC_ST_RUPDIS 2
`define GCSC_ST_VOK 1
// Flags word bit positions
`define GCSC_FL_HOT 15
`define GCSC_FL_COLD 14
`define GCSC_FL_NVMF 10
`define GCSC_FL_FULL 9
`define GCSC_FL_CHG 8
`define GCSC_FL_OCV 7
`define GCSC_FL_RST 5
`define GCSC_FL_CFG 4
`define GCSC_FL_DET 3
`define GCSC_FL_LOW_CHARGE_WARN 2
`define GCSC_FL_FINAL_CHARGE_WARN 1
`define GCSC_FL_DSG 0
// Autocal start delay: 3 min 45 s
`define GCSC_AUTOCAL_S 64'hE1
`define GCSC_CLK_HZ 64'h2FAF080
`define GCSC_AUTOCAL_CYC (`GCSC_AUTOCAL_S * `GCSC_CLK_HZ)
`endif

// >>> gcsc_pkg.sv
// Types for the gauge control and status command block
`default_nettype none
package gcsc_pkg;
   typedef struct packed {
      logic [15:0] voltage;
      logic [15:0] nac;
      logic [15:0] fac;
      logic [15:0] rm;
      logic [15:0] fcc;
      logic [15:0] avg_i;
      logic [15:0] stby_i;
      logic [15:0] max_i;
      logic [15:0] avg_p;
      logic [15:0] soc;
      logic [15:0] die_kelvin;
   } gcsc_meas_t;
   typedef struct packed {
      logic [7:0] low_charge_warn_set;
      logic [7:0] low_charge_warn_clr;
      logic [7:0] final_charge_warn_set;
      logic [7:0] final_charge_warn_clr;
   } gcsc_thresh_t;
   typedef struct packed {
      logic calibration_active_bit;
      logic bca;
      logic sleep;
      logic table_update_block_bit;
      logic voltage_fit_bit;
      logic hot;
      logic cold;
      logic full;
      logic charging_allowed;
      logic ocv;
      logic draining_flag;
      logic cap_update;
      logic res_update;
      logic nvm_fail_evt;
      logic hib_exit;
   } gcsc_gauge_t;
   typedef enum {GC_IDLE, GC_CCA_WAIT, GC_CCA_RUN} gcsc_cal_t;
endpackage
`default_nettype wire

// >>> gcsc_core.sv
// Control subcommand decoder, status and flags words, standard word reads
// What this block does
// - Status subcommand puts the status word in the control pair.
// - Status word layout: sealed, cal, autocal, board cal, learned, hib, etc.
// - Counter autocal starts about 3 min 45 s after init, bit set while running.
// - Capacity-learned sets on update, clears at reset or cell detection.
// - Resistance-learned sets only after capacity update; same clears.
// - Identity, firmware and hardware queries return their codes.
// - Previous-command query returns last subcommand, always below 0x0015.
// - Insert command sets cell-present and starts gauging when pin detect off.
// - Remove command clears cell-present when pin detect off.
// - Arm command sets hibernate request; clears when hibernate exits.
// - Disarm command clears both request bits and forces hibernate exit.
// - Config-edit command sets edit flag only while unsealed.
// - Factory restore resets learned values while unsealed.
// - Seal command moves device to sealed state.
// - Full reset reloads defaults while unsealed.
// - Soft reset clears reset-seen and config-edit flags while unsealed.
// - Temperature word: host-written when selected, else internal sensor.
// - Flags word is read-only with fixed bit layout.
// - NVM write fault latches and blocks writes until power-on or full reset.
// - Reset-seen sets on power-on or full reset, clears only on soft reset.
// - With pin detect on, falling edge on sense pin sets cell-present.
// - Low-charge flags set at or below set level, clear at clear level.
`timescale 1ns/1ns
`default_nettype none
`include "gcsc_params.svh"
module gcsc_core #(
   parameter logic [63:0] AUTOCAL_CYCLES = `GCSC_AUTOCAL_CYC,
   parameter logic [31:0] AUTOCAL_RUN = 32'h0000_03E8,
   parameter logic [15:0] IDENT_CODE = 16'hA5A5, // Arbitrary value
   parameter logic [15:0] FW_CODE = 16'h0100, // Arbitrary value
   parameter logic [15:0] HW_CODE = 16'h0001, // Arbitrary value
   parameter logic SEAL_DEFAULT = 1'b0
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   output logic [15:0] RDATA,
   output logic RVALID,
   input wire logic PIN_DETECT_ENABLE,
   input wire logic HOST_KELVIN_SELECT,
   input wire logic INTERNAL_KELVIN_WRITE_SELECT,
   input wire logic CELL_SENSE_PIN,
   input wire gcsc_pkg::gcsc_meas_t MEAS,
   input wire gcsc_pkg::gcsc_thresh_t THRESH,
   input wire gcsc_pkg::gcsc_gauge_t GAUGE,
   output logic GAUGING_RUN,
   output logic CONFIG_EDIT,
   output logic NVM_WRITE_ALLOW,
   output logic RESTORE_PULSE,
   output logic FULL_RESET_PULSE,
   output logic SOFT_RESET_PULSE,
   output logic HIB_FORCE_EXIT,
   output logic [15:0] GAUGE_KELVIN
);
   import gcsc_pkg::*;

   logic [15:0] ctrl_ff, prev_ff, host_k_ff, status_w, flags_w;
   logic sealed_ff, hib_ff, hib_alt_ff, cfg_ff, rst_seen_ff, det_ff;
   logic qlearn_ff, rlearn_ff, nvmf_ff, low_charge_warn_ff, final_charge_warn_ff;
   logic [2:0] pin_sync_ff;
   logic pin_last_ff, pin_fall;
   logic [63:0] cal_cnt_ff;
   gcsc_cal_t cal_ff;
   logic ctrl_wr, sc_ok, first_ff;

   // Soft-only commands are dropped when sealed
   function automatic logic needs_unseal(input logic [15:0] sc);
      case (sc)
         `GCSC_SC_PREV, `GCSC_SC_CFG, `GCSC_SC_RESTORE, `GCSC_SC_SEAL,
         `GCSC_SC_FULLRST, `GCSC_SC_SOFTRST: needs_unseal = 1'b1;
         default: needs_unseal = 1'b0;
      endcase
   endfunction

   assign ctrl_wr = WR_STB && (ADDR == `GCSC_OFF_CTRL);
   assign sc_ok = ctrl_wr && !(sealed_ff && needs_unseal(WDATA));
   function automatic logic is_sc(input logic [15:0] sc);
      is_sc = sc_ok && (WDATA == sc);
   endfunction

   // Pin passes three flops; a change counts when the last two agree
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pin_sync_ff <= 3'h7;
         pin_last_ff <= 1'b1;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], CELL_SENSE_PIN};
         if (pin_sync_ff[2] == pin_sync_ff[1]) begin
            pin_last_ff <= pin_sync_ff[2];
         end
      end
   end
   assign pin_fall = pin_last_ff && !pin_sync_ff[2] && !pin_sync_ff[1];

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         sealed_ff <= 1'b0;
         first_ff <= 1'b1;
      end else begin
         first_ff <= 1'b0;
         if (first_ff) begin
            sealed_ff <= SEAL_DEFAULT;
         end else if (is_sc(`GCSC_SC_SEAL)) begin
            sealed_ff <= 1'b1;
         end
      end
   end

   // Last subcommand; holds only codes under the limit
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         prev_ff <= 16'h0000;
      end else if (sc_ok && WDATA < `GCSC_PREV_LIMIT && WDATA != `GCSC_SC_PREV) begin
         prev_ff <= WDATA;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ctrl_ff <= 16'h0000;
      end else if (sc_ok) begin
         case (WDATA)
            `GCSC_SC_STATUS: ctrl_ff <= status_w;
            `GCSC_SC_IDENT: ctrl_ff <= IDENT_CODE;
            `GCSC_SC_FWREV: ctrl_ff <= FW_CODE;
            `GCSC_SC_HWREV: ctrl_ff <= HW_CODE;
            `GCSC_SC_PREV: ctrl_ff <= prev_ff;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         hib_ff <= 1'b0;
         hib_alt_ff <= 1'b0;
         HIB_FORCE_EXIT <= 1'b0;
      end else begin
         HIB_FORCE_EXIT <= is_sc(`GCSC_SC_HIB_CLR);
         if (is_sc(`GCSC_SC_HIB_CLR)) begin
            hib_ff <= 1'b0;
            hib_alt_ff <= 1'b0;
         end else if (is_sc(`GCSC_SC_HIB_SET)) begin
            hib_ff <= 1'b1;
         end else if (GAUGE.hib_exit) begin
            hib_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cfg_ff <= 1'b0;
         rst_seen_ff <= 1'b1;
      end else begin
         if (is_sc(`GCSC_SC_CFG)) begin
            cfg_ff <= 1'b1;
         end else if (is_sc(`GCSC_SC_SOFTRST) || is_sc(`GCSC_SC_FULLRST)) begin
            cfg_ff <= 1'b0;
         end
         if (is_sc(`GCSC_SC_FULLRST)) begin
            rst_seen_ff <= 1'b1;
         end else if (is_sc(`GCSC_SC_SOFTRST)) begin
            rst_seen_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         det_ff <= 1'b0;
         GAUGING_RUN <= 1'b0;
      end else begin
         if (PIN_DETECT_ENABLE) begin
            if (pin_fall) begin
               det_ff <= 1'b1;
               GAUGING_RUN <= 1'b1;
            end
         end else if (is_sc(`GCSC_SC_INSERT)) begin
            det_ff <= 1'b1;
            GAUGING_RUN <= 1'b1;
         end else if (is_sc(`GCSC_SC_REMOVE)) begin
            det_ff <= 1'b0;
         end
         if (is_sc(`GCSC_SC_FULLRST)) begin
            GAUGING_RUN <= 1'b0;
         end
      end
   end

   // Learned bits: detection and restore win over a same-cycle update
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         qlearn_ff <= 1'b0;
         rlearn_ff <= 1'b0;
      end else if ((PIN_DETECT_ENABLE ? pin_fall : is_sc(`GCSC_SC_INSERT))
                   || is_sc(`GCSC_SC_RESTORE) || is_sc(`GCSC_SC_FULLRST)) begin
         qlearn_ff <= 1'b0;
         rlearn_ff <= 1'b0;
      end else begin
         if (GAUGE.cap_update) begin
            qlearn_ff <= 1'b1;
         end
         if (GAUGE.res_update && qlearn_ff) begin
            rlearn_ff <= 1'b1;
         end
      end
   end

   // A new fault wins over a full reset in the same cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         nvmf_ff <= 1'b0;
      end else if (GAUGE.nvm_fail_evt) begin
         nvmf_ff <= 1'b1;
      end else if (is_sc(`GCSC_SC_FULLRST)) begin
         nvmf_ff <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         low_charge_warn_ff <= 1'b0;
         final_charge_warn_ff <= 1'b0;
      end else begin
         if (MEAS.soc[7:0] <= THRESH.low_charge_warn_set) begin
            low_charge_warn_ff <= 1'b1;
         end else if (MEAS.soc[7:0] >= THRESH.low_charge_warn_clr) begin
            low_charge_warn_ff <= 1'b0;
         end
         if (MEAS.soc[7:0] <= THRESH.final_charge_warn_set) begin
            final_charge_warn_ff <= 1'b1;
         end else if (MEAS.soc[7:0] >= THRESH.final_charge_warn_clr) begin
            final_charge_warn_ff <= 1'b0;
         end
      end
   end

   // Autocal timer counts from init; restarts after a full reset
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cal_ff <= GC_CCA_WAIT;
         cal_cnt_ff <= 64'h0;
      end else if (is_sc(`GCSC_SC_FULLRST)) begin
         cal_ff <= GC_CCA_WAIT;
         cal_cnt_ff <= 64'h0;
      end else begin
         case (cal_ff)
            GC_CCA_WAIT: begin
               cal_cnt_ff <= cal_cnt_ff + 64'h1;
               if (cal_cnt_ff >= AUTOCAL_CYCLES - 64'h1) begin
                  cal_ff <= GC_CCA_RUN;
                  cal_cnt_ff <= 64'h0;
               end
            end
            GC_CCA_RUN: begin
               cal_cnt_ff <= cal_cnt_ff + 64'h1;
               if (cal_cnt_ff >= {32'h0, AUTOCAL_RUN} - 64'h1) begin
                  cal_ff <= GC_IDLE;
               end
            end
            default: cal_cnt_ff <= 64'h0;
         endcase
      end
   end

   always_comb begin
      status_w = 16'h0000;
      status_w[`GCSC_ST_SEALED] = sealed_ff;
      status_w[`GCSC_ST_CALIBRATION_ACTIVE_BIT] = GAUGE.calibration_active_bit;
      status_w[`GCSC_ST_CCA] = (cal_ff == GC_CCA_RUN);
      status_w[`GCSC_ST_BCA] = GAUGE.bca;
      status_w[`GCSC_ST_QLEARN] = qlearn_ff;
      status_w[`GCSC_ST_RLEARN] = rlearn_ff;
      status_w[`GCSC_ST_HIB] = hib_ff;
      status_w[`GCSC_ST_SLEEP] = GAUGE.sleep;
      status_w[`GCSC_ST_CPWR] = 1'b1;
      status_w[`GCSC_ST_RUPDIS] = GAUGE.table_update_block_bit;
      status_w[`GCSC_ST_VOK] = GAUGE.voltage_fit_bit;
   end

   always_comb begin
      flags_w = 16'h0000;
      flags_w[`GCSC_FL_HOT] = GAUGE.hot;
      flags_w[`GCSC_FL_COLD] = GAUGE.cold;
      flags_w[`GCSC_FL_NVMF] = nvmf_ff;
      flags_w[`GCSC_FL_FULL] = GAUGE.full;
      flags_w[`GCSC_FL_CHG] = GAUGE.charging_allowed;
      flags_w[`GCSC_FL_OCV] = GAUGE.ocv;
      flags_w[`GCSC_FL_RST] = rst_seen_ff;
      flags_w[`GCSC_FL_CFG] = cfg_ff;
      flags_w[`GCSC_FL_DET] = det_ff;
      flags_w[`GCSC_FL_LOW_CHARGE_WARN] = low_charge_warn_ff;
      flags_w[`GCSC_FL_FINAL_CHARGE_WARN] = final_charge_warn_ff;
      flags_w[`GCSC_FL_DSG] = GAUGE.draining_flag;
   end

   // Host temperature is kept even while deselected, so re-selecting reuses it
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         host_k_ff <= 16'h0000;
      end else if (WR_STB && ADDR == `GCSC_OFF_TEMP && HOST_KELVIN_SELECT) begin
         host_k_ff <= WDATA;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 16'h0000;
         RVALID <= 1'b0;
         GAUGE_KELVIN <= 16'h0000;
      end else begin
         RVALID <= RD_STB;
         GAUGE_KELVIN <= HOST_KELVIN_SELECT ? host_k_ff : MEAS.die_kelvin;
         if (RD_STB) begin
            case (ADDR)
               `GCSC_OFF_CTRL: RDATA <= ctrl_ff;
               `GCSC_OFF_TEMP: RDATA <= HOST_KELVIN_SELECT ? host_k_ff : MEAS.die_kelvin;
               `GCSC_OFF_VOLT: RDATA <= MEAS.voltage;
               `GCSC_OFF_FLAGS: RDATA <= flags_w;
               `GCSC_OFF_NAC: RDATA <= MEAS.nac;
               `GCSC_OFF_FAC: RDATA <= MEAS.fac;
               `GCSC_OFF_RM: RDATA <= MEAS.rm;
               `GCSC_OFF_FCC: RDATA <= MEAS.fcc;
               `GCSC_OFF_AI: RDATA <= MEAS.avg_i;
               `GCSC_OFF_SI: RDATA <= MEAS.stby_i;
               `GCSC_OFF_MLI: RDATA <= MEAS.max_i;
               `GCSC_OFF_AP: RDATA <= MEAS.avg_p;
               `GCSC_OFF_SOC: RDATA <= MEAS.soc;
               `GCSC_OFF_ITEMP: RDATA <= INTERNAL_KELVIN_WRITE_SELECT ?
                                          MEAS.die_kelvin :
                                          (HOST_KELVIN_SELECT ? host_k_ff : MEAS.die_kelvin);
               default: RDATA <= 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         CONFIG_EDIT <= 1'b0;
         NVM_WRITE_ALLOW <= 1'b1;
         RESTORE_PULSE <= 1'b0;
         FULL_RESET_PULSE <= 1'b0;
         SOFT_RESET_PULSE <= 1'b0;
      end else begin
         CONFIG_EDIT <= cfg_ff;
         NVM_WRITE_ALLOW <= !nvmf_ff;
         RESTORE_PULSE <= is_sc(`GCSC_SC_RESTORE);
         FULL_RESET_PULSE <= is_sc(`GCSC_SC_FULLRST);
         SOFT_RESET_PULSE <= is_sc(`GCSC_SC_SOFTRST);
      end
   end
endmodule
`default_nettype wire

// >>> gcsc_core_chk.sv
// Port-level assertions for the gauge command block
`timescale 1ns/1ns
`default_nettype none
`include "gcsc_params.svh"
module gcsc_core_chk #(
   parameter logic [15:0] IDENT_CODE = 16'hA5A5 // Arbitrary value
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic WR_STB,
   input wire logic RD_STB,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic [15:0] RDATA,
   input wire logic RVALID,
   input wire logic PIN_DETECT_ENABLE,
   input wire logic HOST_KELVIN_SELECT,
   input wire gcsc_pkg::gcsc_gauge_t GAUGE,
   input wire logic GAUGING_RUN,
   input wire logic CONFIG_EDIT,
   input wire logic NVM_WRITE_ALLOW,
   input wire logic RESTORE_PULSE,
   input wire logic FULL_RESET_PULSE,
   input wire logic SOFT_RESET_PULSE,
   input wire logic HIB_FORCE_EXIT,
   input wire logic [15:0] GAUGE_KELVIN
);
   import gcsc_pkg::*;
   logic ctl_wr;
   logic sealed_ff;
   logic [15:0] temp_ff;
   default clocking chk_cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   assign ctl_wr = WR_STB && ADDR == `GCSC_OFF_CTRL;
   // Sealing is tracked one way only, since nothing here unseals
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         sealed_ff <= 1'b0;
      end else if (ctl_wr && WDATA == `GCSC_SC_SEAL) begin
         sealed_ff <= 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (WR_STB && ADDR == `GCSC_OFF_TEMP) begin
         temp_ff <= WDATA;
      end
   end
   read_reply_a: assert property (RD_STB |=> RVALID)
      else $error("read got no reply");
   ident_reply_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_IDENT ##[1:2] RD_STB && ADDR == 8'h00 |=> RDATA == IDENT_CODE)
      else $error("identity reply wrong");
   temp_take_a: assert property (
      WR_STB && ADDR == `GCSC_OFF_TEMP && HOST_KELVIN_SELECT |=> ##[0:1] GAUGE_KELVIN == temp_ff)
      else $error("host temperature not taken");
   nvm_block_a: assert property (GAUGE.nvm_fail_evt |-> ##[1:2] !NVM_WRITE_ALLOW)
      else $error("write fault did not block");
   full_reset_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_FULLRST && !sealed_ff |=> FULL_RESET_PULSE)
      else $error("full reset not issued");
   soft_reset_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_SOFTRST && !sealed_ff |=> SOFT_RESET_PULSE)
      else $error("soft reset not issued");
   sealed_refuse_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_RESTORE && sealed_ff |=> !RESTORE_PULSE)
      else $error("restore honoured while sealed");
   edit_enter_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_CFG && !sealed_ff |-> ##2 CONFIG_EDIT)
      else $error("config edit not entered");
   insert_run_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_INSERT && !PIN_DETECT_ENABLE |=> GAUGING_RUN)
      else $error("insert did not start gauging");
   hib_force_a: assert property (
      ctl_wr && WDATA == `GCSC_SC_HIB_CLR |=> HIB_FORCE_EXIT)
      else $error("hibernate exit not forced");
endmodule
`default_nettype wire

// >>> gcsc_host.sv
// Host model issuing whole-word reads and writes to the gauge block
`timescale 1ns/1ns
`default_nettype none
module gcsc_host (
   input wire logic CORE_CLK,
   output var logic WR_STB,
   output var logic RD_STB,
   output var logic [7:0] ADDR,
   output var logic [15:0] WDATA,
   input wire logic [15:0] RDATA,
   input wire logic RVALID
);
   initial begin
      WR_STB = 1'b0;
      RD_STB = 1'b0;
      ADDR = 8'h00;
      WDATA = 16'h0000;
   end
   // Released lines show the inverse so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge CORE_CLK);
      WR_STB <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CORE_CLK);
      WR_STB <= 1'b0;
      ADDR <= ~a;
      WDATA <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      int n;
      @(posedge CORE_CLK);
      RD_STB <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD_STB <= 1'b0;
      ADDR <= ~a;
      ok = 1'b0;
      d = 16'h0000;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge CORE_CLK);
         if (RVALID === 1'b1) begin
            ok = 1'b1;
            d = RDATA;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> gcsc_core_tb_top.sv
// Self-checking bench for the gauge command block
`timescale 1ns/1ns
`default_nettype none
`include "gcsc_params.svh"
module gcsc_core_tb_top;
   import gcsc_pkg::*;
   localparam int ACAL = 3000;
   localparam logic [15:0] IDC = 16'h5A3C; // Arbitrary value
   localparam logic [15:0] FWC = 16'h0203; // Arbitrary value
   localparam logic [15:0] HWC = 16'h0004; // Arbitrary value
   localparam logic [7:0] OFS [10] = '{8'h04, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14,
      8'h18, 8'h1C};
   localparam logic [7:0] SOCV [6] = '{8'h0A, 8'h03, 8'h05, 8'h06, 8'h0C, 8'h0F};
   localparam logic [15:0] SOCE [6] = '{16'h0004, 16'h0006, 16'h0006, 16'h0004, 16'h0004,
      16'h0000};
   logic clk, rst, wr, rdq, pde, hks, iks, pin, rv, gr, ce, nwa;
   logic [7:0] ad;
   logic [15:0] wd, rdat, gk;
   gcsc_meas_t meas;
   gcsc_thresh_t th;
   gcsc_gauge_t g;
   int error_cnt = 0;
   int n_checks = 0;
   gcsc_host gcsc_host_inst (.CORE_CLK(clk), .WR_STB(wr), .RD_STB(rdq), .ADDR(ad), .WDATA(wd),
      .RDATA(rdat), .RVALID(rv));
   gcsc_core #(.AUTOCAL_CYCLES(64'(ACAL)), .IDENT_CODE(IDC), .FW_CODE(FWC), .HW_CODE(HWC))
   gcsc_core_inst (.CORE_CLK(clk), .RST(rst), .WR_STB(wr), .RD_STB(rdq), .ADDR(ad),
      .WDATA(wd), .RDATA(rdat), .RVALID(rv), .PIN_DETECT_ENABLE(pde),
      .HOST_KELVIN_SELECT(hks), .INTERNAL_KELVIN_WRITE_SELECT(iks), .CELL_SENSE_PIN(pin),
      .MEAS(meas), .THRESH(th), .GAUGE(g), .GAUGING_RUN(gr), .CONFIG_EDIT(ce),
      .NVM_WRITE_ALLOW(nwa), .RESTORE_PULSE(), .FULL_RESET_PULSE(), .SOFT_RESET_PULSE(),
      .HIB_FORCE_EXIT(), .GAUGE_KELVIN(gk));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] m,
      input logic [15:0] e);
      logic [15:0] d;
      logic ok;
      gcsc_host_inst.rd(a, d, ok);
      chk({nm, " reply"}, {15'h0000, ok}, 16'h0001);
      chk(nm, d & m, e);
   endtask
   task automatic sc(input logic [15:0] c);
      gcsc_host_inst.wr(8'h00, c);
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      sc(`GCSC_SC_STATUS);
      rc("status", 8'h00, m, e);
   endtask
   task automatic fl(input logic [15:0] m, input logic [15:0] e);
      rc("flags", `GCSC_OFF_FLAGS, m, e);
   endtask
   // One-cycle gauge event on bit b of the gauge struct
   task automatic ev(input int b);
      @(posedge clk);
      g[b] <= 1'b1;
      @(posedge clk);
      g[b] <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #(20 * 12000);
      error_cnt++;
      wrap_up();
   end
   initial begin
      int k;
      rst = 1'b1;
      pde = 1'b0;
      hks = 1'b0;
      iks = 1'b0;
      pin = 1'b1;
      g = '0;
      th = {8'h0A, 8'h0F, 8'h03, 8'h06};
      for (k = 0; k < 11; k++) meas[175 - 16 * k -: 16] = 16'h1100 + 16'(k);
      meas.soc = 16'h0032;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      fl(16'hFFFF, 16'h0020);
      st(16'hFFFF, 16'h0008);
      rc("unmapped", 8'h16, 16'hFFFF, 16'h0000);
      sc(`GCSC_SC_IDENT);
      rc("ident", 8'h00, 16'hFFFF, IDC);
      sc(`GCSC_SC_FWREV);
      rc("firmware", 8'h00, 16'hFFFF, FWC);
      sc(`GCSC_SC_HWREV);
      rc("hardware", 8'h00, 16'hFFFF, HWC);
      sc(`GCSC_SC_PREV);
      rc("previous", 8'h00, 16'hFFFF, `GCSC_SC_HWREV);
      for (k = 0; k < 10; k++) rc("measure", OFS[k], 16'hFFFF, meas[175 - 16 * k -: 16]);
      // All level inputs high at once to expose any swapped bit position
      @(posedge clk) g[14:4] <= 11'h7FF;
      gcsc_host_inst.wr(`GCSC_OFF_FLAGS, 16'h0000);
      fl(16'hFFFF, 16'hC3A1);
      st(16'hFFFF, 16'h141E);
      @(posedge clk) g[14:4] <= 11'h000;
      @(posedge clk) hks <= 1'b1;
      gcsc_host_inst.wr(`GCSC_OFF_TEMP, 16'h0BB8);
      rc("temperature", `GCSC_OFF_TEMP, 16'hFFFF, 16'h0BB8);
      chk("gauge temperature", gk, 16'h0BB8);
      @(posedge clk) hks <= 1'b0;
      gcsc_host_inst.wr(`GCSC_OFF_TEMP, 16'h0123);
      rc("sensor", `GCSC_OFF_TEMP, 16'hFFFF, meas.die_kelvin);
      // Reselecting must show the old host value, proving the deselected write was dropped
      @(posedge clk) hks <= 1'b1;
      rc("kept", `GCSC_OFF_TEMP, 16'hFFFF, 16'h0BB8);
      rc("itemp follows", `GCSC_OFF_ITEMP, 16'hFFFF, 16'h0BB8);
      @(posedge clk) iks <= 1'b1;
      rc("die sensor", `GCSC_OFF_ITEMP, 16'hFFFF, meas.die_kelvin);
      ev(2);
      st(16'h0300, 16'h0000);
      ev(3);
      st(16'h0300, 16'h0200);
      ev(2);
      st(16'h0300, 16'h0300);
      sc(`GCSC_SC_INSERT);
      fl(16'h0008, 16'h0008);
      chk("gauging", {15'h0000, gr}, 16'h0001);
      st(16'h0300, 16'h0000);
      sc(`GCSC_SC_REMOVE);
      fl(16'h0008, 16'h0000);
      ev(3);
      sc(`GCSC_SC_RESTORE);
      st(16'h0300, 16'h0000);
      @(posedge clk) pde <= 1'b1;
      @(posedge clk) pin <= 1'b0;
      repeat (5) @(posedge clk);
      fl(16'h0008, 16'h0008);
      for (k = 0; k < 6; k++) begin
         @(posedge clk) meas.soc <= {8'h00, SOCV[k]};
         fl(16'h0006, SOCE[k]);
      end
      sc(`GCSC_SC_HIB_SET);
      st(16'h0040, 16'h0040);
      ev(0);
      st(16'h0040, 16'h0000);
      sc(`GCSC_SC_HIB_SET);
      sc(`GCSC_SC_HIB_CLR);
      st(16'h0040, 16'h0000);
      sc(`GCSC_SC_CFG);
      fl(16'h0030, 16'h0030);
      chk("config edit", {15'h0000, ce}, 16'h0001);
      sc(`GCSC_SC_SOFTRST);
      fl(16'h0030, 16'h0000);
      ev(1);
      fl(16'h0400, 16'h0400);
      chk("nvm allow", {15'h0000, nwa}, 16'h0000);
      sc(`GCSC_SC_FULLRST);
      fl(16'h0430, 16'h0020);
      chk("nvm allow", {15'h0000, nwa}, 16'h0001);
      chk("gauging", {15'h0000, gr}, 16'h0000);
      // Reset codes lie above the limit, so the last stored code is still config edit
      sc(`GCSC_SC_PREV);
      rc("previous", 8'h00, 16'hFFFF, `GCSC_SC_CFG);
      st(16'h0800, 16'h0000);
      repeat (ACAL) @(posedge clk);
      st(16'h0800, 16'h0800);
      sc(`GCSC_SC_SEAL);
      st(16'h2000, 16'h2000);
      sc(`GCSC_SC_CFG);
      sc(`GCSC_SC_RESTORE);
      fl(16'h0010, 16'h0000);
      wrap_up();
   end
endmodule
bind gcsc_core gcsc_core_chk #(.IDENT_CODE(IDENT_CODE)) gcsc_core_chk_inst (
   .CORE_CLK(CORE_CLK), .RST(RST), .WR_STB(WR_STB), .RD_STB(RD_STB), .ADDR(ADDR),
   .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID), .PIN_DETECT_ENABLE(PIN_DETECT_ENABLE),
   .HOST_KELVIN_SELECT(HOST_KELVIN_SELECT), .GAUGE(GAUGE), .GAUGING_RUN(GAUGING_RUN),
   .CONFIG_EDIT(CONFIG_EDIT), .NVM_WRITE_ALLOW(NVM_WRITE_ALLOW), .RESTORE_PULSE(RESTORE_PULSE),
   .FULL_RESET_PULSE(FULL_RESET_PULSE), .SOFT_RESET_PULSE(SOFT_RESET_PULSE),
   .HIB_FORCE_EXIT(HIB_FORCE_EXIT), .GAUGE_KELVIN(GAUGE_KELVIN));
`default_nettype wire
